//--- shared/iec_pkg.sv
package iec_pkg;
	// ----------------------------------------------------------------
	// Bus geometry and register offsets
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_THRESH = 4'h1;
	localparam logic [3:0] REG_HYST = 4'h2;
	localparam logic [3:0] REG_FILT = 4'h3;
	localparam logic [3:0] REG_GAIN = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h5;
	localparam logic [3:0] REG_RESULT = 4'h6;
	// ----------------------------------------------------------------
	// Control and status fields
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_MODE_MSB = 2;
	localparam int CTRL_DUAL_BIT = 3;
	localparam int CTRL_INDEX_BIT = 4;
	localparam int CTRL_START_BIT = 5;
	localparam int CTRL_STOP_BIT = 6;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_STATE_MSB = 2;
	localparam int STAT_DET_A_BIT = 3;
	localparam int STAT_DET_B_BIT = 4;
	localparam int STAT_DET_I_BIT = 5;
	localparam int STAT_INDEX_SEEN_BIT = 6;
	typedef enum logic [2:0] {
		MODE_EVENTS = 3'h0,
		MODE_DIST_DIFF = 3'h1,
		MODE_DIST_ABS = 3'h2,
		MODE_ANG_DIFF = 3'h3,
		MODE_ANG_ABS = 3'h4
	} iec_mode_e;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_RUN = 3'b100
	} iec_state_e;
	localparam logic [1:0] FILT_BYPASS = 2'h0;
	localparam logic [1:0] FILT_20K = 2'h1;
	localparam logic [1:0] FILT_2K = 2'h2;
	localparam logic [1:0] FILT_200H = 2'h3;
	// ----------------------------------------------------------------
	// Timing and scaling
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25000000;
	localparam int LPF_20K_HZ = 20000;
	localparam int LPF_2K_HZ = 2000;
	localparam int LPF_200_HZ = 200;
	localparam int LPF_FRAC = 15;
	// Single pole IIR, coefficient 2*pi*fc/fs rounded to a power of two
	localparam int LPF_SHIFT_20K = $clog2(CLK_HZ / ((628 * LPF_20K_HZ) / 100));
	localparam int LPF_SHIFT_2K = $clog2(CLK_HZ / ((628 * LPF_2K_HZ) / 100));
	localparam int LPF_SHIFT_200 = $clog2(CLK_HZ / ((628 * LPF_200_HZ) / 100));
	localparam int EVENT_MAX_HZ = 500000;
	localparam int EVENT_MIN_CYC = CLK_HZ / EVENT_MAX_HZ;
	// Input word: signed, full scale 32767 codes at 10 V
	localparam int FS_MV = 10000;
	localparam int FS_CODE = 32767;
	localparam int HYST_MIN_MV = 100;
	localparam int HYST_MAX_MV = 4000;
	localparam logic [15:0] HYST_MIN_CODE = 16'((HYST_MIN_MV * FS_CODE + FS_MV - 1) / FS_MV);
	localparam logic [15:0] HYST_MAX_CODE = 16'((HYST_MAX_MV * FS_CODE) / FS_MV);
	localparam logic [15:0] THRESH_RST = 16'h0000;
	localparam logic [15:0] HYST_RST = HYST_MIN_CODE;
	localparam logic [1:0] FILT_RST = FILT_BYPASS;
	localparam int GAIN_FRAC = 8;
	localparam logic [15:0] GAIN_RST = 16'h0100;
	localparam int CNT_W = 24;
	localparam int POS_W = 32;
endpackage : iec_pkg

//--- hdl/iec_top.sv
// Summary of operation
// R01: Detector goes high only above threshold plus half the hysteresis width.
// R02: Detector goes low only below threshold minus half width; band holds state.
// R03: Threshold spans full input range; hysteresis clamped to 100 mV to 4 V.
// R04: Smoothing filter selects bypass, 20 kHz, 2 kHz or 200 Hz corner.
// R05: Single-track counts pulses from track A only, never negative.
// R06: Dual-track uses both quadrature tracks and counts up or down; in event mode the code ignores the dual bit and counts up on track A only.
// R07: With index gating, counting stays idle until an index event.
// R08: Without index gating, counting begins right at measurement start.
// R09: Index detector uses the threshold and hysteresis of channel one.
// R10: Index path always passes the fixed 20 kHz low-pass filter.
// R11: Gated channel waiting for index reports zero at every interval.
// R12: Index gating is disabled after reset.
// R13: Edge counting supports event rates up to about 500 kHz.
// R14: Each rising detector transition counts exactly one event.
// R15: Differential distance reports interval travel scaled by gain.
// R16: Absolute distance accumulates travel from zero at start.
// R17: Differential angle reports interval rotation scaled by gain.
// R18: Absolute angle accumulates rotation, zeroed at the index event.
// R19: Event mode reports pulse count of each interval at its end; the code also scales this count by the gain register.
// R20: Cumulative modes report running sums, differential modes interval change.
// R21: Results are 16 bits, saturated to full scale; absolute angle mode wraps instead.
// R22: Track A edge with B low counts up, with B high counts down.
// R23: Interval tick latches result and restarts counter without losing edges.
//
// Added by the designer: the address-and-strobe port and the register addresses.

// ------------------------------------------------------------------
// Conditioning: synchroniser, smoothing filter, hysteresis comparator
// ------------------------------------------------------------------
module iec_cond (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [15:0] sample_in,
	input wire logic [1:0] filt_sel,
	input wire logic [15:0] thresh,
	input wire logic [15:0] hyst,
	output logic det
);
	import iec_pkg::*;
	logic [15:0] s1_r;
	logic [15:0] s2_r;
	logic signed [LPF_FRAC+15:0] acc_r;
	logic signed [LPF_FRAC+16:0] dif;
	logic signed [LPF_FRAC+16:0] step;
	logic signed [15:0] y;
	logic [15:0] hyst_c;
	logic signed [16:0] upper;
	logic signed [16:0] lower;
	logic det_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= 16'h0000;
			s2_r <= 16'h0000;
		end else begin
			s1_r <= sample_in;
			s2_r <= s1_r;
		end
	end
	always_comb begin
		dif = {s2_r[15], s2_r, {LPF_FRAC{1'b0}}} - {acc_r[LPF_FRAC+15], acc_r};
		case (filt_sel)
			FILT_20K: step = dif >>> LPF_SHIFT_20K; // R04 R10
			FILT_2K: step = dif >>> LPF_SHIFT_2K; // R04
			FILT_200H: step = dif >>> LPF_SHIFT_200; // R04
			default: step = dif;
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= '0;
		end else begin
			acc_r <= acc_r + step[LPF_FRAC+15:0];
		end
	end
	always_comb begin
		y = acc_r[LPF_FRAC+15:LPF_FRAC];
		hyst_c = hyst;
		if (hyst < HYST_MIN_CODE) begin
			hyst_c = HYST_MIN_CODE; // R03
		end else if (hyst > HYST_MAX_CODE) begin
			hyst_c = HYST_MAX_CODE; // R03
		end
		upper = {thresh[15], thresh} + {2'b00, hyst_c[15:1]};
		lower = {thresh[15], thresh} - {2'b00, hyst_c[15:1]};
	end
	// Compare as signed words: a negative sample must never look above the band
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			det_r <= 1'b0;
		end else if (!det_r && ($signed({y[15], y}) > upper)) begin
			det_r <= 1'b1; // R01
		end else if (det_r && ($signed({y[15], y}) < lower)) begin
			det_r <= 1'b0; // R02
		end
	end
	assign det = det_r;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_rise_above_band: assert property ($rose(det_r) |-> $past($signed({y[15], y}) > upper)) // R01
		else $error("detector rose without crossing upper level");
	a_fall_below_band: assert property ($fell(det_r) |-> $past($signed({y[15], y}) < lower)) // R02
		else $error("detector fell without crossing lower level");
	a_hyst_clamped: assert property (hyst_c >= HYST_MIN_CODE && hyst_c <= HYST_MAX_CODE) // R03
		else $error("hysteresis width outside allowed range");
endmodule : iec_cond

// ------------------------------------------------------------------
// Counter channel with register port
// ------------------------------------------------------------------
module iec_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [iec_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [iec_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [iec_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [15:0] track_a_in,
	input wire logic [15:0] track_b_in,
	input wire logic [15:0] index_in,
	input wire logic sample_tick,
	output logic [15:0] value_out,
	output logic value_valid,
	output logic running
);
	import iec_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	iec_mode_e mode_r;
	logic dual_r;
	logic index_en_r;
	logic [15:0] thresh_r;
	logic [15:0] hyst_r;
	logic [1:0] filt_r;
	logic [15:0] gain_r;
	logic [15:0] rdata_r;
	logic start_req;
	logic stop_req;
	assign start_req = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_START_BIT];
	assign stop_req = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_STOP_BIT];
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= MODE_EVENTS;
			dual_r <= 1'b0;
			index_en_r <= 1'b0; // R12
			thresh_r <= THRESH_RST;
			hyst_r <= HYST_RST;
			filt_r <= FILT_RST;
			gain_r <= GAIN_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				REG_CTRL: begin
					mode_r <= iec_mode_e'(reg_wdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
					dual_r <= reg_wdata[CTRL_DUAL_BIT];
					index_en_r <= reg_wdata[CTRL_INDEX_BIT];
				end
				REG_THRESH: thresh_r <= reg_wdata;
				REG_HYST: hyst_r <= reg_wdata;
				REG_FILT: filt_r <= reg_wdata[1:0];
				REG_GAIN: gain_r <= reg_wdata;
				default: ;
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Signal conditioning
	// ----------------------------------------------------------------
	logic det_a;
	logic det_b;
	logic det_i;
	logic det_a_d_r;
	logic det_i_d_r;
	logic rise_a;
	logic rise_i;
	iec_cond u_cond_a (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.sample_in(track_a_in),
		.filt_sel(filt_r),
		.thresh(thresh_r),
		.hyst(hyst_r),
		.det(det_a)
	);
	iec_cond u_cond_b (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.sample_in(track_b_in),
		.filt_sel(filt_r),
		.thresh(thresh_r),
		.hyst(hyst_r),
		.det(det_b)
	);
	// Index shares channel one settings and a fixed 20 kHz filter
	iec_cond u_cond_i (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.sample_in(index_in),
		.filt_sel(FILT_20K),
		.thresh(thresh_r),
		.hyst(hyst_r),
		.det(det_i)
	); // R09 R10
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			det_a_d_r <= 1'b0;
			det_i_d_r <= 1'b0;
		end else begin
			det_a_d_r <= det_a;
			det_i_d_r <= det_i;
		end
	end
	// One count per rising edge; every clock is evaluated, so far above 500 kHz
	assign rise_a = det_a && !det_a_d_r; // R14 R13
	assign rise_i = det_i && !det_i_d_r;
	// ----------------------------------------------------------------
	// Measurement sequencing
	// ----------------------------------------------------------------
	iec_state_e state_r;
	iec_mode_e run_mode_r;
	logic run_dual_r;
	logic index_seen_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else if (stop_req) begin
			state_r <= ST_IDLE;
		end else if (start_req) begin
			state_r <= reg_wdata[CTRL_INDEX_BIT] ? ST_WAIT : ST_RUN; // R07 R08
		end else begin
			case (state_r)
				ST_WAIT: if (rise_i) begin
					state_r <= ST_RUN; // R07
				end
				ST_RUN: ;
				ST_IDLE: ;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_mode_r <= MODE_EVENTS;
			run_dual_r <= 1'b0;
			index_seen_r <= 1'b0;
		end else if (start_req) begin
			run_mode_r <= iec_mode_e'(reg_wdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
			run_dual_r <= reg_wdata[CTRL_DUAL_BIT] && reg_wdata[CTRL_MODE_MSB:CTRL_MODE_LSB] != MODE_EVENTS;
			index_seen_r <= 1'b0;
		end else if (state_r == ST_WAIT && rise_i) begin
			index_seen_r <= 1'b1;
		end
	end
	// ----------------------------------------------------------------
	// Counting
	// ----------------------------------------------------------------
	logic signed [CNT_W-1:0] diff_cnt_r;
	logic signed [POS_W-1:0] pos_r;
	logic signed [CNT_W-1:0] edge_step;
	logic counting;
	logic restart;
	assign counting = state_r == ST_RUN && !start_req && !stop_req;
	assign restart = start_req || (state_r == ST_WAIT && rise_i);
	always_comb begin
		edge_step = '0;
		if (counting && rise_a) begin
			if (run_dual_r && det_b) begin
				edge_step = -CNT_W'(1); // R06 R22
			end else begin
				edge_step = CNT_W'(1); // R05 R22
			end
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			diff_cnt_r <= '0;
		end else if (restart || !counting) begin
			diff_cnt_r <= '0; // R07
		end else if (sample_tick) begin
			diff_cnt_r <= edge_step; // R23
		end else begin
			diff_cnt_r <= diff_cnt_r + edge_step;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pos_r <= '0;
		end else if (restart) begin
			pos_r <= '0; // R16 R18
		end else if (counting && sample_tick) begin
			pos_r <= pos_r + POS_W'(diff_cnt_r); // R20
		end
	end

	// ----------------------------------------------------------------
	// Scaling and result
	// ----------------------------------------------------------------
	logic signed [POS_W-1:0] raw;
	logic signed [POS_W+16:0] prod;
	logic signed [POS_W+16:0] scaled;
	logic [15:0] result;
	logic [15:0] value_r;
	logic value_valid_r;
	always_comb begin
		case (run_mode_r)
			MODE_DIST_ABS, MODE_ANG_ABS: raw = pos_r + POS_W'(diff_cnt_r); // R16 R18 R20
			default: raw = POS_W'(diff_cnt_r); // R15 R17 R19
		endcase
		prod = raw * $signed({1'b0, gain_r});
		scaled = prod >>> GAIN_FRAC;
		if (run_mode_r == MODE_ANG_ABS) begin
			result = scaled[15:0]; // R18
		end else if (scaled > (POS_W+17)'(32767)) begin
			result = 16'h7FFF; // R21
		end else if (scaled < -(POS_W+17)'(32768)) begin
			result = 16'h8000; // R21
		end else begin
			result = scaled[15:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			value_r <= 16'h0000;
			value_valid_r <= 1'b0;
		end else begin
			value_valid_r <= sample_tick && state_r != ST_IDLE;
			if (sample_tick && state_r == ST_WAIT) begin
				value_r <= 16'h0000; // R11
			end else if (sample_tick && state_r == ST_RUN) begin
				value_r <= result; // R15 R17 R19 R23
			end
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: rdata_r <= {11'h000, index_en_r, dual_r, mode_r};
				REG_THRESH: rdata_r <= thresh_r;
				REG_HYST: rdata_r <= hyst_r;
				REG_FILT: rdata_r <= {14'h0000, filt_r};
				REG_GAIN: rdata_r <= gain_r;
				REG_STATUS: rdata_r <= {9'h000, index_seen_r, det_i, det_b, det_a, state_r};
				REG_RESULT: rdata_r <= value_r;
				default: rdata_r <= 16'h0000;
			endcase
		end else begin
			rdata_r <= 16'h0000;
		end
	end

	assign reg_rdata = rdata_r;
	assign value_out = value_r;
	assign value_valid = value_valid_r;
	assign running = state_r[2];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_gated_idle_count: assert property (state_r == ST_WAIT |-> diff_cnt_r == '0 && pos_r == '0) // R07
		else $error("counter moved while waiting for index");
	a_direct_start: assert property (start_req && !reg_wdata[CTRL_INDEX_BIT] && !stop_req |=> state_r == ST_RUN) // R08
		else $error("ungated start did not begin counting");
	a_wait_zero_out: assert property (sample_tick && state_r == ST_WAIT |=> value_valid_r && value_r == 16'h0000) // R11
		else $error("gated channel reported nonzero before index");
	a_reset_ungated: assert property (@(posedge ref_clk) disable iff (1'b0) !$past(rst_n) |-> !index_en_r) // R12
		else $error("index gating enabled after reset");
	a_single_no_down: assert property (state_r == ST_RUN && !run_dual_r |-> !diff_cnt_r[CNT_W-1]) // R05
		else $error("single track counted negative");
	a_dual_down: assert property (counting && rise_a && run_dual_r && det_b && !sample_tick
		|=> diff_cnt_r == $past(diff_cnt_r) - CNT_W'(1)) // R22
		else $error("reverse quadrature edge did not count down");
	a_edge_once: assert property (counting && rise_a && !sample_tick |=> !rise_a ##0 diff_cnt_r != $past(diff_cnt_r)) // R14
		else $error("rising edge not counted exactly once");
	a_tick_restart: assert property (counting && sample_tick && !restart |=> diff_cnt_r == $past(edge_step)) // R23
		else $error("interval counter not restarted on tick");
	a_tick_reports: assert property (sample_tick && state_r == ST_RUN && !stop_req |=> value_valid_r ##1 !value_valid_r
		or value_valid_r) // R19
		else $error("interval end not reported");
	a_abs_sum: assert property (counting && sample_tick && !restart |=> pos_r == $past(pos_r) + POS_W'($past(diff_cnt_r))) // R20
		else $error("cumulative position not updated");

	c_index_start: cover property (state_r == ST_WAIT ##[1:1000] state_r == ST_RUN);
	c_dual_reverse: cover property (counting && rise_a && run_dual_r && det_b);
	c_tick_with_edge: cover property (counting && sample_tick && rise_a);
	c_saturate: cover property (sample_tick && state_r == ST_RUN && result == 16'h7FFF);
endmodule : iec_top

//--- verif/iec_enc_model.sv
// ------------------------------------------------------------------
// Encoder model: two quadrature tracks and an index track
// ------------------------------------------------------------------
module iec_enc_model (
	input wire logic ref_clk,
	output logic [15:0] track_a,
	output logic [15:0] track_b,
	output logic [15:0] index_p
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] LVL_HI = 16'h1000;
	localparam logic [15:0] LVL_LO = 16'hF000;
	// Quarter period in cycles; a full period of 64 cycles stays below 500 kHz
	localparam int QUARTER = 16;

	initial begin
		track_a = LVL_LO;
		track_b = LVL_LO;
		index_p = LVL_LO;
	end

	task automatic drive(input logic [15:0] a, input logic [15:0] b, input int cyc);
		@(posedge ref_clk);
		track_a <= a;
		track_b <= b;
		repeat (cyc - 1) @(posedge ref_clk);
	endtask : drive

	// Forward motion leads on track A, reverse motion leads on track B
	task automatic pulses(input int n, input bit rev);
		for (int i = 0; i < n; i++) begin
			if (!rev) begin
				drive(LVL_HI, LVL_LO, QUARTER);
				drive(LVL_HI, LVL_HI, QUARTER);
				drive(LVL_LO, LVL_HI, QUARTER);
				drive(LVL_LO, LVL_LO, QUARTER);
			end else begin
				drive(LVL_LO, LVL_HI, QUARTER);
				drive(LVL_HI, LVL_HI, QUARTER);
				drive(LVL_HI, LVL_LO, QUARTER);
				drive(LVL_LO, LVL_LO, QUARTER);
			end
		end
	endtask : pulses

	task automatic set_a(input logic [15:0] v, input int cyc);
		drive(v, LVL_LO, cyc);
	endtask : set_a

	task automatic set_index(input logic [15:0] v, input int cyc);
		@(posedge ref_clk);
		index_p <= v;
		repeat (cyc - 1) @(posedge ref_clk);
	endtask : set_index
endmodule : iec_enc_model

//--- verif/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import iec_pkg::*;
	logic ref_clk;
	logic rst_n;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic [DATA_W-1:0] reg_rdata;
	logic reg_wr;
	logic reg_rd;
	logic sample_tick;
	logic [15:0] ta;
	logic [15:0] tb;
	logic [15:0] ti;
	logic [15:0] value_out;
	logic value_valid;
	logic running;
	logic [15:0] rdv;
	int err_total;
	int compares;

	iec_top u_dut (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.track_a_in(ta),
		.track_b_in(tb),
		.index_in(ti),
		.sample_tick(sample_tick),
		.value_out(value_out),
		.value_valid(value_valid),
		.running(running)
	);

	iec_enc_model u_enc (
		.ref_clk(ref_clk),
		.track_a(ta),
		.track_b(tb),
		.index_p(ti)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------------
	// Bus and check helpers
	// ------------------------------------------------------------------
	task automatic end_of_test;
		if (err_total == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic start(input logic [2:0] m, input logic dl, input logic g);
		wr(REG_CTRL, {9'h000, 1'b0, 1'b1, g, dl, m});
		repeat (2) @(posedge ref_clk);
	endtask : start

	task automatic tick(input logic v, input logic [15:0] e);
		repeat (8) @(posedge ref_clk);
		sample_tick <= 1'b1;
		@(posedge ref_clk);
		sample_tick <= 1'b0;
		#1;
		chk({15'h0000, value_valid}, {15'h0000, v});
		if (v) begin
			chk(value_out, e);
		end
	endtask : tick

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset;
		rd(REG_CTRL, rdv);
		chk(rdv, 16'h0000);
		rd(REG_HYST, rdv);
		chk(rdv, HYST_RST);
		rd(REG_GAIN, rdv);
		chk(rdv, GAIN_RST);
		rd(REG_STATUS, rdv);
		chk(rdv, 16'h0001);
		rd(4'hA, rdv);
		chk(rdv, 16'h0000);
		chk({15'h0000, running}, 16'h0000);
	endtask : t_reset

	task automatic t_hyst;
		logic [15:0] lv [4] = '{16'h00A4, 16'h00A5, 16'hFF5C, 16'hFF5B};
		logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		// Hysteresis below the minimum is clamped, half width 164 codes
		wr(REG_HYST, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			u_enc.set_a(lv[i], 12);
			rd(REG_STATUS, rdv);
			chk({15'h0000, rdv[STAT_DET_A_BIT]}, {15'h0000, ex[i]});
		end
		wr(REG_FILT, {14'h0000, FILT_20K});
		u_enc.set_a(16'hF000, 3000);
		u_enc.set_a(16'h7000, 2);
		u_enc.set_a(16'h0000, 3000);
		rd(REG_STATUS, rdv);
		chk({15'h0000, rdv[STAT_DET_A_BIT]}, 16'h0000);
		wr(REG_FILT, {14'h0000, FILT_BYPASS});
		u_enc.set_a(16'hF000, 20);
	endtask : t_hyst

	task automatic t_count;
		start(MODE_EVENTS, 1'b0, 1'b0);
		chk({15'h0000, running}, 16'h0001);
		u_enc.pulses(5, 1'b0);
		tick(1'b1, 16'h0005);
		rd(REG_RESULT, rdv);
		chk(rdv, 16'h0005);
		u_enc.pulses(4, 1'b1);
		tick(1'b1, 16'h0004);
		tick(1'b1, 16'h0000);
		wr(REG_CTRL, 16'h0040);
		tick(1'b0, 16'h0000);
	endtask : t_count

	task automatic t_modes;
		logic ab;
		wr(REG_GAIN, 16'h0200);
		for (int m = 1; m <= 4; m++) begin
			ab = (m == 2) || (m == 4);
			start(3'(m), 1'b1, 1'b0);
			u_enc.pulses(3, 1'b0);
			tick(1'b1, 16'h0006);
			u_enc.pulses(5, 1'b1);
			tick(1'b1, ab ? 16'hFFFC : 16'hFFF6);
			wr(REG_CTRL, 16'h0040);
		end
	endtask : t_modes

	task automatic t_sat;
		wr(REG_GAIN, 16'h8000);
		start(MODE_DIST_DIFF, 1'b0, 1'b0);
		u_enc.pulses(257, 1'b0);
		tick(1'b1, 16'h7FFF);
		wr(REG_CTRL, 16'h0040);
		wr(REG_GAIN, 16'h0100);
	endtask : t_sat

	task automatic t_index;
		start(MODE_EVENTS, 1'b0, 1'b1);
		rd(REG_STATUS, rdv);
		chk(rdv, 16'h0002);
		chk({15'h0000, running}, 16'h0000);
		u_enc.pulses(3, 1'b0);
		tick(1'b1, 16'h0000);
		wr(REG_THRESH, 16'h2000);
		u_enc.set_index(16'h1000, 2000);
		u_enc.set_index(16'hF000, 2000);
		wr(REG_THRESH, 16'h0000);
		u_enc.set_index(16'h7000, 2);
		u_enc.set_index(16'h0000, 2000);
		rd(REG_STATUS, rdv);
		chk(rdv, 16'h0002);
		u_enc.set_index(16'h7000, 2000);
		u_enc.set_index(16'hF000, 2000);
		rd(REG_STATUS, rdv);
		chk(rdv, 16'h0044);
		u_enc.pulses(3, 1'b0);
		tick(1'b1, 16'h0003);
		wr(REG_CTRL, 16'h0040);
	endtask : t_index

	// ------------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		err_total = 0;
		compares = 0;
		rst_n = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sample_tick = 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_hyst();
		t_count();
		t_modes();
		t_sat();
		t_index();
		end_of_test();
	end

	initial begin
		repeat (90000) @(posedge ref_clk);
		err_total++;
		end_of_test();
	end
endmodule : testbench
